// ---- design/opr_fault_ctrl.sv ----
`timescale 1ns/1ps
module opr_fault_ctrl #(
  parameter int STEP_CYCLES = opr_pkg::STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] cmdCode,
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic rdEn,
  output logic [15:0] rdData,
  input wire logic clearFaults,
  input wire logic outputEnable,
  input wire logic biasGood,
  input wire logic restartOk,
  input wire logic shutdownFault,
  input wire logic [10:0] measuredPower,
  input wire logic ovFault,
  input wire logic ocFault,
  input wire logic uvFault,
  input wire logic tempEvent,
  input wire logic commFault,
  input wire logic otherEvent,
  output logic powerStageEn,
  output logic opWarnFlag,
  output logic opFaultFlag
);
  logic [7:0] response_reg, response_next;
  logic [15:0] warnLimit_reg, warnLimit_next;
  logic [15:0] faultLimit_reg, faultLimit_next;
  logic [15:0] rdData_reg, rdData_next;
  logic [5:0] sticky_reg, sticky_next;
  logic opWarn_reg, opWarn_next;
  logic opFault_reg, opFault_next;
  opr_pkg::opr_state_e state_reg, state_next;
  logic [2:0] attempts_reg, attempts_next;
  logic enable_reg, enable_next;
  logic timerStart;
  logic timerDone;
  logic overWarn;
  logic overFault;
  logic commandedOff;
  logic [1:0] respMode;
  logic [2:0] retryCode;
  logic [7:0] statusByte;

  assign respMode = response_reg[opr_pkg::RESP_HI:opr_pkg::RESP_LO];
  assign retryCode = response_reg[opr_pkg::RETRY_HI:opr_pkg::RETRY_LO];
  assign commandedOff = !outputEnable || !biasGood;

  assign overWarn =
    measuredPower > warnLimit_reg[opr_pkg::MANT_HI:0];
  assign overFault =
    measuredPower > faultLimit_reg[opr_pkg::MANT_HI:0];

  opr_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) retryTimer (
    .clk(clk),
    .rstn(rstn),
    .start(timerStart),
    .steps(response_reg[opr_pkg::DELAY_HI:opr_pkg::DELAY_LO]),
    .done(timerDone)
  );

  // configuration registers
  always_comb begin
    response_next = response_reg;
    warnLimit_next = warnLimit_reg;
    faultLimit_next = faultLimit_reg;
    if (wrEn) begin
      unique case (cmdCode)
        opr_pkg::CMD_RESPONSE: response_next = wrData[7:0];
        opr_pkg::CMD_WARN_LIMIT:
          warnLimit_next = {opr_pkg::LIN_EXP, wrData[opr_pkg::MANT_HI:0]};
        opr_pkg::CMD_FAULT_LIMIT:
          faultLimit_next = {opr_pkg::LIN_EXP, wrData[opr_pkg::MANT_HI:0]};
        default: ;
      endcase
    end
  end

  always_comb begin
    statusByte = {1'b0, !enable_reg, sticky_reg};
  end

  always_comb begin
    rdData_next = rdData_reg;
    if (rdEn) begin
      unique case (cmdCode)
        opr_pkg::CMD_RESPONSE: rdData_next = {8'h00, response_reg};
        opr_pkg::CMD_WARN_LIMIT: rdData_next = warnLimit_reg;
        opr_pkg::CMD_FAULT_LIMIT: rdData_next = faultLimit_reg;
        opr_pkg::CMD_STATUS: rdData_next = {8'h00, statusByte};
        default: rdData_next = 16'h0000;
      endcase
    end
  end

  // sticky flags: an event in the clearing cycle still sets
  always_comb begin
    sticky_next = sticky_reg;
    opWarn_next = opWarn_reg;
    opFault_next = opFault_reg;
    if (clearFaults) begin
      sticky_next = 6'h00;
      opWarn_next = 1'b0;
      opFault_next = 1'b0;
    end
    if (ovFault) sticky_next[opr_pkg::ST_OV] = 1'b1;
    if (ocFault) sticky_next[opr_pkg::ST_OC] = 1'b1;
    if (uvFault) sticky_next[opr_pkg::ST_UV] = 1'b1;
    if (tempEvent) sticky_next[opr_pkg::ST_TEMP] = 1'b1;
    if (commFault) sticky_next[opr_pkg::ST_COMM] = 1'b1;
    if (otherEvent || shutdownFault || overWarn || overFault) begin
      sticky_next[opr_pkg::ST_OTHER] = 1'b1;
    end
    if (overWarn) opWarn_next = 1'b1;
    if (overFault) opFault_next = 1'b1;
  end

  // restart sequencer
  always_comb begin
    state_next = state_reg;
    attempts_next = attempts_reg;
    enable_next = enable_reg;
    timerStart = 1'b0;
    unique case (state_reg)
      opr_pkg::StIdle: begin
        enable_next = 1'b0;
        if (!commandedOff) begin
          state_next = opr_pkg::StRun;
          enable_next = 1'b1;
        end
      end
      opr_pkg::StRun: begin
        if (commandedOff) begin
          state_next = opr_pkg::StIdle;
          enable_next = 1'b0;
        end else if (shutdownFault) begin
          state_next = opr_pkg::StLatched;
          enable_next = 1'b0;
        end else if (overFault &&
                     respMode == opr_pkg::RESP_DISABLE_RETRY) begin
          enable_next = 1'b0;
          if (retryCode == opr_pkg::RETRY_NONE) begin
            state_next = opr_pkg::StLatched;
          end else begin
            state_next = opr_pkg::StWait;
            timerStart = 1'b1;
          end
        end
      end
      opr_pkg::StWait: begin
        enable_next = 1'b0;
        // only command, bias or shutdown stop it
        if (commandedOff) begin
          state_next = opr_pkg::StIdle;
          attempts_next = 3'h0;
        end else if (shutdownFault) begin
          state_next = opr_pkg::StLatched;
        end else if (timerDone) begin
          // next spacing counts from this attempt start
          state_next = opr_pkg::StAttempt;
          enable_next = 1'b1;
          timerStart = 1'b1;
          if (retryCode != opr_pkg::RETRY_FOREVER) begin
            attempts_next = attempts_reg + 3'h1;
          end
        end
      end
      opr_pkg::StAttempt: begin
        if (commandedOff) begin
          state_next = opr_pkg::StIdle;
          enable_next = 1'b0;
          attempts_next = 3'h0;
        end else if (shutdownFault) begin
          state_next = opr_pkg::StLatched;
          enable_next = 1'b0;
        end else if (overFault) begin
          enable_next = 1'b0;
          if (retryCode != opr_pkg::RETRY_FOREVER &&
              attempts_reg >= retryCode) begin
            state_next = opr_pkg::StLatched;
          end else begin
            state_next = opr_pkg::StWait;
          end
        end else if (restartOk) begin
          state_next = opr_pkg::StRun;
          attempts_next = 3'h0;
        end
      end
      opr_pkg::StLatched: begin
        enable_next = 1'b0;
        if (clearFaults) begin
          state_next = opr_pkg::StIdle;
          attempts_next = 3'h0;
        end
      end
      default: begin
        state_next = opr_pkg::StIdle;
        enable_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      response_reg <= opr_pkg::RESPONSE_RST;
      warnLimit_reg <= opr_pkg::LIMIT_RST;
      faultLimit_reg <= opr_pkg::LIMIT_RST;
      rdData_reg <= 16'h0000;
      sticky_reg <= 6'h00;
      opWarn_reg <= 1'b0;
      opFault_reg <= 1'b0;
      state_reg <= opr_pkg::StIdle;
      attempts_reg <= 3'h0;
      enable_reg <= 1'b0;
    end else begin
      response_reg <= response_next;
      warnLimit_reg <= warnLimit_next;
      faultLimit_reg <= faultLimit_next;
      rdData_reg <= rdData_next;
      sticky_reg <= sticky_next;
      opWarn_reg <= opWarn_next;
      opFault_reg <= opFault_next;
      state_reg <= state_next;
      attempts_reg <= attempts_next;
      enable_reg <= enable_next;
    end
  end

  assign rdData = rdData_reg;
  assign powerStageEn = enable_reg;
  assign opWarnFlag = opWarn_reg;
  assign opFaultFlag = opFault_reg;
endmodule

// ---- design/opr_pkg.sv ----
// How it works
// - low three bits: 200 ms step count
// - response 00 keeps output running
// - response 10 disables, then follows retries
// - retry 000: stay off until cleared
// - retry 1..6 attempts, then latch off
// - spacing measured attempt start to start
// - retry 111 repeats until commanded off
// - warning threshold linear, exponent three
// - flag only when power strictly exceeds
// - bit 6 shows output not delivering
// - bit 5 latches output overvoltage
// - bit 4 latches output overcurrent
// - bit 3 latches input undervoltage
// - bit 2 latches temperature events
// - bit 1 latches comm/memory/logic faults
// - bit 0 latches any other event
// - enable cycling keeps latched flags
// - fault threshold linear, exponent three
package opr_pkg;
  localparam logic [7:0] CMD_FAULT_LIMIT = 8'h68;
  localparam logic [7:0] CMD_RESPONSE = 8'h69;
  localparam logic [7:0] CMD_WARN_LIMIT = 8'h6a;
  localparam logic [7:0] CMD_STATUS = 8'h78;
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MANT_HI = 10;
  localparam logic [4:0] LIN_EXP = 5'h03;
  localparam int ST_OFF = 6;
  localparam int ST_OV = 5;
  localparam int ST_OC = 4;
  localparam int ST_UV = 3;
  localparam int ST_TEMP = 2;
  localparam int ST_COMM = 1;
  localparam int ST_OTHER = 0;
  localparam logic [7:0] RESPONSE_RST = 8'h80;
  localparam logic [15:0] LIMIT_RST = 16'h1bff;
  localparam int STEP_MS = 200;
  localparam int CLK_HZ = 40000000;
  localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
  localparam int STEP_W = 24;
  typedef enum logic [2:0] {
    StIdle, StRun, StWait, StAttempt, StLatched
  } opr_state_e;
endpackage

// ---- design/opr_step_timer.sv ----
`timescale 1ns/1ps
// counts a number of fixed-length steps, pulses done at the end
module opr_step_timer #(
  parameter int STEP_CYCLES = opr_pkg::STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [2:0] steps,
  output logic done
);
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [2:0] remain_reg, remain_next;
  logic [opr_pkg::STEP_W-1:0] cyc_reg, cyc_next;
  localparam logic [opr_pkg::STEP_W-1:0] CYC_LAST =
    opr_pkg::STEP_W'(STEP_CYCLES - 1);

  always_comb begin
    busy_next = busy_reg;
    remain_next = remain_reg;
    cyc_next = cyc_reg;
    done_next = 1'b0;
    if (start) begin
      // a fresh start restarts the spacing from this cycle
      busy_next = 1'b1;
      remain_next = steps;
      cyc_next = '0;
    end else if (busy_reg) begin
      if (remain_reg == 3'h0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else if (cyc_reg == CYC_LAST) begin
        cyc_next = '0;
        remain_next = remain_reg - 3'h1;
      end else begin
        cyc_next = cyc_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      remain_reg <= 3'h0;
      cyc_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      remain_reg <= remain_next;
      cyc_reg <= cyc_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule

// ---- sim/opr_fault_checker.sv ----
`timescale 1ns/1ps
module opr_fault_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] cmdCode,
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic rdEn,
  input wire logic [15:0] rdData,
  input wire logic clearFaults,
  input wire logic outputEnable,
  input wire logic biasGood,
  input wire logic shutdownFault,
  input wire logic [10:0] measuredPower,
  input wire logic ovFault,
  input wire logic ocFault,
  input wire logic uvFault,
  input wire logic tempEvent,
  input wire logic commFault,
  input wire logic otherEvent,
  input wire logic powerStageEn,
  input wire logic opWarnFlag,
  input wire logic opFaultFlag
);
  logic [10:0] warnReg, faultReg;
  logic [7:0] respReg;
  logic [5:0] events;
  logic rdStatus, runOk;
  assign events = {ovFault, ocFault, uvFault, tempEvent, commFault, otherEvent};
  assign rdStatus = rdEn && cmdCode == opr_pkg::CMD_STATUS;
  assign runOk = outputEnable && biasGood && !shutdownFault && !clearFaults;
  // shadow copies of the writable settings, mirrored from the command port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      warnReg <= opr_pkg::LIMIT_RST[10:0];
      faultReg <= opr_pkg::LIMIT_RST[10:0];
      respReg <= opr_pkg::RESPONSE_RST;
    end else if (wrEn) begin
      if (cmdCode == opr_pkg::CMD_WARN_LIMIT) warnReg <= wrData[10:0];
      if (cmdCode == opr_pkg::CMD_FAULT_LIMIT) faultReg <= wrData[10:0];
      if (cmdCode == opr_pkg::CMD_RESPONSE) respReg <= wrData[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence held_off3;
    !powerStageEn [*3];
  endsequence
  sequence held_off8;
    !powerStageEn [*8];
  endsequence
  warn_flag_set_a: assert property (
    measuredPower > warnReg |=> opWarnFlag) else $error("warn flag missed");
  fault_flag_set_a: assert property (
    measuredPower > faultReg |=> opFaultFlag) else $error("fault flag missed");
  flag_sticky_a: assert property (
    opWarnFlag && !clearFaults |=> opWarnFlag) else $error("warn flag lost");
  off_bit_a: assert property (
    rdStatus |=> rdData[6] == !$past(powerStageEn) && rdData[15:7] == 9'h000)
    else $error("off bit wrong");
  event_bits_a: assert property (
    rdStatus |=> (rdData[5:0] & $past(events, 2)) == $past(events, 2))
    else $error("status event bit missing");
  limit_exp_a: assert property (
    rdEn && (cmdCode == opr_pkg::CMD_WARN_LIMIT ||
    cmdCode == opr_pkg::CMD_FAULT_LIMIT) |=> rdData[15:11] == opr_pkg::LIN_EXP)
    else $error("limit exponent wrong");
  ignore_keep_a: assert property (
    powerStageEn && runOk && respReg[7:6] != opr_pkg::RESP_DISABLE_RETRY
    |=> powerStageEn) else $error("ignored fault stopped output");
  no_retry_off_a: assert property (
    powerStageEn && measuredPower > faultReg && respReg[7:3] == 5'h10
    |=> held_off8) else $error("output restarted without retries");
  retry_gap_a: assert property (
    $fell(powerStageEn) |-> held_off3) else $error("restart too soon");
  stay_off_a: assert property (
    !(biasGood && outputEnable) |=> !powerStageEn)
    else $error("output on without bias or enable");
endmodule
bind opr_fault_ctrl opr_fault_checker chk (.*);

// ---- sim/opr_host.sv ----
`timescale 1ns/1ps
// host side of the command port; data is scrambled when idle so a stale
// value is never mistaken for a live one
module opr_host (
  input wire logic clk,
  output logic [7:0] cmdCode,
  output logic wrEn,
  output logic [15:0] wrData,
  output logic rdEn,
  input wire logic [15:0] rdData
);
  initial begin
    cmdCode = 8'h00;
    wrEn = 1'b0;
    wrData = 16'h0000;
    rdEn = 1'b0;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #2;
    cmdCode = c;
    wrData = d;
    wrEn = 1'b1;
    @(posedge clk);
    #2;
    wrEn = 1'b0;
    wrData = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk);
    #2;
    cmdCode = c;
    rdEn = 1'b1;
    @(posedge clk);
    #2;
    rdEn = 1'b0;
    d = rdData;
  endtask
endmodule

// ---- sim/overpower_fault_response_status_test.sv ----
`timescale 1ns/1ps
module overpower_fault_response_status_test;
  localparam int STEP = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clearFaults = 1'b0;
  logic outputEnable = 1'b0;
  logic biasGood = 1'b1;
  logic restartOk = 1'b0;
  logic shutdownFault = 1'b0;
  logic [10:0] measuredPower = 11'h000;
  logic [5:0] ev = 6'h00;
  logic ovFault, ocFault, uvFault, tempEvent, commFault, otherEvent;
  logic wrEn, rdEn, powerStageEn, opWarnFlag, opFaultFlag, prevEn;
  logic [7:0] cmdCode;
  logic [15:0] wrData, rdData, got, wd;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 70;
  int cnt, gap, fellAt, n, mWarn, mFault;
  assign {ovFault, ocFault, uvFault, tempEvent, commFault, otherEvent} = ev;
  initial begin
    forever #12.5 clk = ~clk;
  end
  opr_host host (.*);
  opr_fault_ctrl #(.STEP_CYCLES(STEP)) dut (.*);
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic rd(logic [7:0] c, logic [15:0] exp);
    host.rd(c, got);
    cmp($sformatf("reg %h", c), exp, got);
  endtask
  task automatic clr();
    clearFaults = 1'b1;
    cyc(1);
    clearFaults = 1'b0;
  endtask
  task automatic wait_on();
    for (int k = 0; k < 20; k++) begin
      if (powerStageEn === 1'b1) return;
      cyc(1);
    end
    cmp("output wait", 16'h0001, 16'(powerStageEn));
    tally_and_finish();
  endtask
  initial begin
    cyc(2);
    rstn = 1'b1;
    host.wr(opr_pkg::CMD_STATUS, 16'hffff);
    host.wr(8'h55, 16'h0000);
    rd(opr_pkg::CMD_RESPONSE, {8'h00, opr_pkg::RESPONSE_RST});
    rd(opr_pkg::CMD_WARN_LIMIT, opr_pkg::LIMIT_RST);
    rd(opr_pkg::CMD_FAULT_LIMIT, opr_pkg::LIMIT_RST);
    rd(opr_pkg::CMD_STATUS, 16'h0040);
    for (int i = 0; i < 3; i++) begin
      wd = 16'($random(seed));
      host.wr(opr_pkg::CMD_WARN_LIMIT, wd);
      rd(opr_pkg::CMD_WARN_LIMIT, {opr_pkg::LIN_EXP, wd[10:0]});
      host.wr(opr_pkg::CMD_FAULT_LIMIT, ~wd);
      rd(opr_pkg::CMD_FAULT_LIMIT, {opr_pkg::LIN_EXP, ~wd[10:0]});
    end
    mWarn = ($random(seed) & 511) + 1;
    mFault = mWarn + 300;
    host.wr(opr_pkg::CMD_WARN_LIMIT, 16'(mWarn));
    host.wr(opr_pkg::CMD_FAULT_LIMIT, 16'(mFault));
    outputEnable = 1'b1;
    wait_on();
    rd(opr_pkg::CMD_STATUS, 16'h0000);
    measuredPower = 11'(mWarn);
    cyc(3);
    cmp("warn flag", 16'h0000, 16'(opWarnFlag));
    measuredPower = 11'(mWarn + 1);
    cyc(2);
    cmp("warn flag", 16'h0001, 16'(opWarnFlag));
    measuredPower = 11'(mFault + 1);
    cyc(23);
    cmp("output", 16'h0000, 16'(powerStageEn));
    rd(opr_pkg::CMD_STATUS, 16'h0041);
    cmp("fault flag", 16'h0001, 16'(opFaultFlag));
    measuredPower = 11'h000;
    clr();
    wait_on();
    for (int i = 0; i < 6; i++) begin
      ev = 6'h01 << i;
      cyc(1);
      ev = 6'h00;
      if (i == 0) begin
        outputEnable = 1'b0;
        cyc(4);
        outputEnable = 1'b1;
        wait_on();
      end
      rd(opr_pkg::CMD_STATUS, 16'(6'h01 << i));
      clr();
    end
    for (int r = 0; r < 4; r++) begin
      if (r == 2) continue;
      host.wr(opr_pkg::CMD_RESPONSE, 16'(r << 6));
      measuredPower = 11'(mFault + 1);
      cyc(10);
      cmp("output", 16'h0001, 16'(powerStageEn));
      measuredPower = 11'h000;
      clr();
    end
    // a second pass of code 2 shows the attempt count starts afresh
    for (int k = 0; k < 9; k++) begin
      n = k % 8 + (k / 8) * 2;
      host.wr(opr_pkg::CMD_RESPONSE, 16'(8'h81 | (n << 3)));
      measuredPower = 11'(mFault + 1);
      prevEn = 1'b1;
      cnt = 0;
      fellAt = -1;
      for (int c = 0; c < 160; c++) begin
        cyc(1);
        if (powerStageEn === 1'b1 && prevEn === 1'b0) begin
          cnt++;
          if (cnt == 1) gap = c - fellAt;
        end
        if (powerStageEn === 1'b0 && fellAt < 0) fellAt = c;
        prevEn = powerStageEn;
      end
      cmp("attempts", 16'(n),
          16'((n == 7 && cnt > 6) ? 7 : cnt));
      // steps of STEP cycles plus one cycle of timer latency and one of sequencer latency
      if (n != 0) cmp("spacing", 16'(STEP + 2), 16'(gap));
      if (n == 7) begin
        biasGood = 1'b0;
        cyc(20);
      end
      cmp("output", 16'h0000, 16'(powerStageEn));
      biasGood = 1'b1;
      measuredPower = 11'h000;
      clr();
      wait_on();
    end
    // a good attempt returns to run and restores the full retry budget
    host.wr(opr_pkg::CMD_RESPONSE, 16'h0091);
    measuredPower = 11'(mFault + 1);
    cyc(2);
    measuredPower = 11'h000;
    restartOk = 1'b1;
    wait_on();
    cyc(2);
    restartOk = 1'b0;
    measuredPower = 11'(mFault + 1);
    cnt = 0;
    prevEn = 1'b1;
    for (int c = 0; c < 80; c++) begin
      cyc(1);
      if (powerStageEn === 1'b1 && prevEn === 1'b0) cnt++;
      prevEn = powerStageEn;
    end
    cmp("attempts", 16'h0002, 16'(cnt));
    cmp("output", 16'h0000, 16'(powerStageEn));
    measuredPower = 11'h000;
    clr();
    wait_on();
    // a forced shutdown latches the output off and reports in bit 0
    shutdownFault = 1'b1;
    cyc(1);
    shutdownFault = 1'b0;
    cyc(3);
    rd(opr_pkg::CMD_STATUS, 16'h0041);
    tally_and_finish();
  end
endmodule
